// ==== include/eetw_pkg.sv ====
// Constants and types for the EEPROM two-wire command and status block.
// Assumes a 10 MHz device clock and a 16-bit management register port.
package eetw_pkg;
   // ****************************************************************
   // Register map and fields
   // ****************************************************************
   localparam logic [4:0] ADDR_CMD = 5'h10;
   localparam logic [4:0] ADDR_STAT = 5'h11;
   localparam logic [4:0] ADDR_CTRL = 5'h12;
   localparam logic [15:0] RST_CMD = 16'h0100;
   localparam logic [15:0] RST_STAT = 16'h0000;
   localparam logic [15:0] RST_CTRL = 16'hA000;
   localparam int CMD_SLV_HI = 15;
   localparam int CMD_SLV_LO = 9;
   localparam int CMD_DIR = 8;
   localparam int CTRL_WT_HI = 15;
   localparam int CTRL_WT_LO = 12;
   localparam int CTRL_RL_HI = 11;
   localparam int CTRL_RL_LO = 10;
   localparam int CTRL_RB = 9;
   // ****************************************************************
   // Status codes
   // ****************************************************************
   localparam logic [2:0] ST_READY = 3'h0;
   localparam logic [2:0] ST_DONE = 3'h1;
   localparam logic [2:0] ST_BUSY = 3'h2;
   localparam logic [2:0] ST_RBFAIL = 3'h3;
   localparam logic [2:0] ST_FAIL = 3'h5;
   localparam logic [2:0] ST_IGN = 3'h7;
   localparam logic [2:0] RL_PART = 3'h2;
   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_NS = 100;
   localparam int QTR_NS = 200;
   localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_UNIT_NS = 1050000;
   localparam int WR_UNIT_CYC_DEF = WR_UNIT_NS / CLK_NS;
   localparam int BLK_BYTES = 128;
   localparam int RAM_BYTES = 256;
   localparam logic [6:0] LAST_IN_BLK = 7'h7F;
   localparam logic [3:0] ACK_BIT = 4'h8;
   // ****************************************************************
   // Sequencer states
   // ****************************************************************
   typedef enum logic [3:0] {
      S_IDLE, S_START, S_DEVW, S_BADDR, S_WDATA,
      S_RSTART, S_DEVR, S_RDATA, S_STOP, S_WAIT
   } eetw_state_e;
endpackage

// ==== rtl/eetw_two_wire_master.sv ====
// Two-wire EEPROM master with byte access, reload to RAM and status.
// Assumes the register port is on the device clock; scl/sda are pins.
//
// What this block does
// - Writing the command register updates the byte-access status field.
// - Byte-access status reads 010 while the command executes.
// - Final byte status persists until status read, the read clears it.
// - A new command without reading overwrites the previous status.
// - A byte command during a byte command is ignored, no 111.
// - Byte codes: 000 ready, 001 done, 010 busy, 101 failed, 111 ignored; 011 unused.
// - Done-without-error when the slave acknowledges every byte before any read-back.
// - Read-back mismatch or missing acknowledge still reports 001.
// - Read-data field holds the EEPROM byte, valid only with 001.
// - Setting the upper reload bit updates the reload status field.
// - Reload status reads 010 until done, final code latches until read.
// - New reload drops old status; reload during reload ignored, no 111.
// - Reload codes: 001 all, 010 second half failed, 101 first half.
// - Status bits 12:11 always read zero.
// - Command write starts a transfer only when the interface is free.
// - Reload field: 0x normal, 10 RAM only, 11 RAM and reinit.
// - With read-back enabled every acknowledged write is read back into read data.
module eetw_two_wire_master #(
   parameter int WR_UNIT_CYC = eetw_pkg::WR_UNIT_CYC_DEF
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata_r,
   input wire logic scl_in,
   output logic scl_out_r,
   output logic scl_oe_r,
   input wire logic sda_in,
   output logic sda_out_r,
   output logic sda_oe_r,
   input wire logic [7:0] ram_addr,
   output logic [7:0] ram_data_r,
   output logic phy_reinit_r
);
   // ****************************************************************
   // State
   // ****************************************************************
   eetw_pkg::eetw_state_e state_r, state_nxt;
   logic [15:0] cmd_r, cmd_nxt, ctrl_r, ctrl_nxt, reg_rdata_nxt;
   logic [2:0] tw_r, tw_nxt, rl_r, rl_nxt;
   logic [7:0] rdbyte_r, rdbyte_nxt, sh_r, sh_nxt;
   logic job_rd_r, job_rd_nxt, job_rl_r, job_rl_nxt, rb_r, rb_nxt;
   logic blk_r, blk_nxt, fail_r, fail_nxt, ack_r, ack_nxt;
   logic [6:0] cnt_r, cnt_nxt;
   logic [1:0] q_r, q_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [7:0] div_r, div_nxt;
   logic [19:0] wait_r, wait_nxt;
   logic scl_oe_nxt, sda_oe_nxt, phy_reinit_nxt;
   logic scl_m_r, scl_s_r, sda_m_r, sda_s_r;
   logic tick, op_done, tw_busy, rl_busy, is_start, is_stop, is_rd;
   logic ram_we, stall;
   logic [7:0] ram_wa;
   logic [7:0] ram [eetw_pkg::RAM_BYTES];

   function automatic logic [7:0] byte_for(
      input eetw_pkg::eetw_state_e s, input logic [15:0] cmd,
      input logic [7:0] wdata, input logic rl, input logic blk);
      logic [7:0] v;
      v = 8'hFF;
      case (s)
         eetw_pkg::S_DEVW: v = {cmd[eetw_pkg::CMD_SLV_HI:
                                    eetw_pkg::CMD_SLV_LO], 1'b0};
         eetw_pkg::S_DEVR: v = {cmd[eetw_pkg::CMD_SLV_HI:
                                    eetw_pkg::CMD_SLV_LO], 1'b1};
         eetw_pkg::S_BADDR: v = rl ? {blk, 7'h00} : cmd[7:0];
         eetw_pkg::S_WDATA: v = wdata;
         default: v = 8'hFF;
      endcase
      return v;
   endfunction

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      state_nxt = state_r;
      cmd_nxt = cmd_r;
      ctrl_nxt = ctrl_r;
      tw_nxt = tw_r;
      rl_nxt = rl_r;
      rdbyte_nxt = rdbyte_r;
      sh_nxt = sh_r;
      job_rd_nxt = job_rd_r;
      job_rl_nxt = job_rl_r;
      rb_nxt = rb_r;
      blk_nxt = blk_r;
      fail_nxt = fail_r;
      ack_nxt = ack_r;
      cnt_nxt = cnt_r;
      q_nxt = q_r;
      bit_nxt = bit_r;
      wait_nxt = wait_r;
      scl_oe_nxt = scl_oe_r;
      sda_oe_nxt = sda_oe_r;
      phy_reinit_nxt = 1'b0;
      reg_rdata_nxt = reg_rdata_r;
      op_done = 1'b0;
      ram_we = 1'b0;
      ram_wa = {blk_r, cnt_r};
      tick = (div_r == 8'h00);
      div_nxt = tick ? 8'(eetw_pkg::QTR_CYC - 1) : div_r - 8'h01;
      tw_busy = (state_r != eetw_pkg::S_IDLE) && !job_rl_r;
      rl_busy = (state_r != eetw_pkg::S_IDLE) && job_rl_r;
      is_start = (state_r == eetw_pkg::S_START) ||
                 (state_r == eetw_pkg::S_RSTART);
      is_stop = (state_r == eetw_pkg::S_STOP);
      is_rd = (state_r == eetw_pkg::S_RDATA);
      // Released clock held low by the slave stretches the bit
      stall = !scl_oe_r && !scl_s_r;

      // Reads; clearing spares a field whose job is still running
      if (reg_rd) begin
         case (reg_addr)
            eetw_pkg::ADDR_CMD: reg_rdata_nxt = cmd_r;
            eetw_pkg::ADDR_STAT: reg_rdata_nxt = {rl_r, 2'b00, tw_r,
                                                 rdbyte_r};
            eetw_pkg::ADDR_CTRL: reg_rdata_nxt = ctrl_r;
            default: reg_rdata_nxt = 16'h0000;
         endcase
         if (reg_addr == eetw_pkg::ADDR_STAT) begin
            if (!tw_busy) tw_nxt = eetw_pkg::ST_READY;
            if (!rl_busy) rl_nxt = eetw_pkg::ST_READY;
         end
      end

      // Command write: start when free, otherwise ignore
      if (reg_wr && reg_addr == eetw_pkg::ADDR_CMD) begin
         if (state_r == eetw_pkg::S_IDLE) begin
            cmd_nxt = reg_wdata;
            tw_nxt = eetw_pkg::ST_BUSY;
            job_rd_nxt = reg_wdata[eetw_pkg::CMD_DIR];
            job_rl_nxt = 1'b0;
            rb_nxt = 1'b0;
            fail_nxt = 1'b0;
            state_nxt = eetw_pkg::S_START;
         end else if (rl_busy) begin
            tw_nxt = eetw_pkg::ST_IGN;
         end
      end

      // Control write; the reload field clears itself at the end
      if (reg_wr && reg_addr == eetw_pkg::ADDR_CTRL) begin
         ctrl_nxt = reg_wdata;
         if (rl_busy) begin
            ctrl_nxt[eetw_pkg::CTRL_RL_HI:eetw_pkg::CTRL_RL_LO] =
               ctrl_r[eetw_pkg::CTRL_RL_HI:eetw_pkg::CTRL_RL_LO];
         end else if (reg_wdata[eetw_pkg::CTRL_RL_HI]) begin
            if (state_r == eetw_pkg::S_IDLE) begin
               rl_nxt = eetw_pkg::ST_BUSY;
               job_rl_nxt = 1'b1;
               job_rd_nxt = 1'b1;
               rb_nxt = 1'b0;
               blk_nxt = 1'b0;
               cnt_nxt = 7'h00;
               fail_nxt = 1'b0;
               state_nxt = eetw_pkg::S_START;
            end else begin
               rl_nxt = eetw_pkg::ST_IGN;
               ctrl_nxt[eetw_pkg::CTRL_RL_HI:eetw_pkg::CTRL_RL_LO] = 2'b00;
            end
         end
      end

      // Bit engine: four quarters per bit, start and stop
      if (state_r != eetw_pkg::S_IDLE && state_r != eetw_pkg::S_WAIT &&
          tick && !stall) begin
         q_nxt = q_r + 2'h1;
         case (q_r)
            2'h0: begin
               if (is_start) sda_oe_nxt = 1'b0;
               else if (is_stop) sda_oe_nxt = 1'b1;
               else if (bit_r == eetw_pkg::ACK_BIT)
                  sda_oe_nxt = is_rd && job_rl_r &&
                               cnt_r != eetw_pkg::LAST_IN_BLK;
               else sda_oe_nxt = !is_rd && !sh_r[7];
            end
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: begin
               if (is_start) sda_oe_nxt = 1'b1;
               else if (is_stop) sda_oe_nxt = 1'b0;
               else if (bit_r == eetw_pkg::ACK_BIT) ack_nxt = sda_s_r;
               else sh_nxt = {sh_r[6:0], is_rd & sda_s_r};
            end
            default: begin
               if (!is_stop) scl_oe_nxt = 1'b1;
               if (is_start || is_stop || bit_r == eetw_pkg::ACK_BIT)
                  op_done = 1'b1;
               else bit_nxt = bit_r + 4'h1;
            end
         endcase
      end

      // Write cycle time before the read-back
      if (state_r == eetw_pkg::S_WAIT) begin
         if (wait_r == 20'h00000) begin
            rb_nxt = 1'b1;
            state_nxt = eetw_pkg::S_START;
         end else begin
            wait_nxt = wait_r - 20'h00001;
         end
      end

      // Byte sequencer; a high ack bit is a refusal
      if (op_done) begin
         q_nxt = 2'h0;
         bit_nxt = 4'h0;
         case (state_r)
            eetw_pkg::S_START: state_nxt = eetw_pkg::S_DEVW;
            eetw_pkg::S_RSTART: state_nxt = eetw_pkg::S_DEVR;
            eetw_pkg::S_DEVW, eetw_pkg::S_BADDR, eetw_pkg::S_DEVR,
            eetw_pkg::S_WDATA: begin
               if (ack_r) begin
                  fail_nxt = 1'b1;
                  state_nxt = eetw_pkg::S_STOP;
               end else if (state_r == eetw_pkg::S_DEVW)
                  state_nxt = eetw_pkg::S_BADDR;
               else if (state_r == eetw_pkg::S_DEVR)
                  state_nxt = eetw_pkg::S_RDATA;
               else if (state_r == eetw_pkg::S_WDATA)
                  state_nxt = eetw_pkg::S_STOP;
               else if (!job_rd_r && !rb_r)
                  state_nxt = eetw_pkg::S_WDATA;
               else state_nxt = eetw_pkg::S_RSTART;
            end
            eetw_pkg::S_RDATA: begin
               if (job_rl_r) begin
                  ram_we = 1'b1;
                  if (cnt_r == eetw_pkg::LAST_IN_BLK) begin
                     cnt_nxt = 7'h00;
                     state_nxt = eetw_pkg::S_STOP;
                  end else begin
                     cnt_nxt = cnt_r + 7'h01;
                  end
               end else begin
                  rdbyte_nxt = sh_r;
                  state_nxt = eetw_pkg::S_STOP;
               end
            end
            default: begin
               if (!fail_r && !job_rd_r && !rb_r &&
                   ctrl_r[eetw_pkg::CTRL_RB]) begin
                  wait_nxt = 20'(ctrl_r[eetw_pkg::CTRL_WT_HI:
                                       eetw_pkg::CTRL_WT_LO]) *
                             20'(WR_UNIT_CYC);
                  state_nxt = eetw_pkg::S_WAIT;
               end else if (job_rl_r && !fail_r && !blk_r) begin
                  blk_nxt = 1'b1;
                  state_nxt = eetw_pkg::S_START;
               end else begin
                  state_nxt = eetw_pkg::S_IDLE;
                  if (job_rl_r) begin
                     rl_nxt = !fail_r ? eetw_pkg::ST_DONE :
                              blk_r ? eetw_pkg::RL_PART :
                              eetw_pkg::ST_FAIL;
                     phy_reinit_nxt = !fail_r &&
                                      ctrl_r[eetw_pkg::CTRL_RL_LO];
                     ctrl_nxt[eetw_pkg::CTRL_RL_HI:eetw_pkg::CTRL_RL_LO] =
                        2'b00;
                  end else begin
                     // Read-back trouble never downgrades the write
                     tw_nxt = (fail_r && !rb_r) ? eetw_pkg::ST_FAIL :
                              eetw_pkg::ST_DONE;
                  end
               end
            end
         endcase
         sh_nxt = byte_for(state_nxt, cmd_r, ctrl_r[7:0], job_rl_r,
                           blk_nxt);
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge clock) begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      scl_out_r <= 1'b0;
      sda_out_r <= 1'b0;
      if (ram_we) ram[ram_wa] <= sh_r;
      ram_data_r <= ram[ram_addr];
      if (rst) begin
         state_r <= eetw_pkg::S_IDLE;
         cmd_r <= eetw_pkg::RST_CMD;
         ctrl_r <= eetw_pkg::RST_CTRL;
         tw_r <= eetw_pkg::RST_STAT[10:8];
         rl_r <= eetw_pkg::RST_STAT[15:13];
         rdbyte_r <= eetw_pkg::RST_STAT[7:0];
         sh_r <= 8'h00;
         job_rd_r <= 1'b0;
         job_rl_r <= 1'b0;
         rb_r <= 1'b0;
         blk_r <= 1'b0;
         fail_r <= 1'b0;
         ack_r <= 1'b0;
         cnt_r <= 7'h00;
         q_r <= 2'h0;
         bit_r <= 4'h0;
         div_r <= 8'h00;
         wait_r <= 20'h00000;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
         phy_reinit_r <= 1'b0;
         reg_rdata_r <= 16'h0000;
      end else begin
         state_r <= state_nxt;
         cmd_r <= cmd_nxt;
         ctrl_r <= ctrl_nxt;
         tw_r <= tw_nxt;
         rl_r <= rl_nxt;
         rdbyte_r <= rdbyte_nxt;
         sh_r <= sh_nxt;
         job_rd_r <= job_rd_nxt;
         job_rl_r <= job_rl_nxt;
         rb_r <= rb_nxt;
         blk_r <= blk_nxt;
         fail_r <= fail_nxt;
         ack_r <= ack_nxt;
         cnt_r <= cnt_nxt;
         q_r <= q_nxt;
         bit_r <= bit_nxt;
         div_r <= div_nxt;
         wait_r <= wait_nxt;
         scl_oe_r <= scl_oe_nxt;
         sda_oe_r <= sda_oe_nxt;
         phy_reinit_r <= phy_reinit_nxt;
         reg_rdata_r <= reg_rdata_nxt;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   chk_byte_busy: assert property (tw_busy |-> tw_r == 3'h2)
      else $error("byte status not busy during job");
   chk_cmd_accept: assert property (
      reg_wr && reg_addr == 5'h10 && state_r == eetw_pkg::S_IDLE
      |=> tw_r == 3'h2 && state_r == eetw_pkg::S_START)
      else $error("free command not started");
   chk_cmd_ignored: assert property (
      reg_wr && reg_addr == 5'h10 && tw_busy
      |=> $stable(cmd_r) && tw_r != 3'h7)
      else $error("busy command not ignored");
   chk_cross_ignore: assert property (
      reg_wr && reg_addr == 5'h10 && rl_busy && !op_done
      |=> tw_r == 3'h7)
      else $error("command during reload not flagged");
   // The read returns the codes as they stood before the clear
   chk_read_clear: assert property (
      reg_rd && reg_addr == 5'h11 && !reg_wr && state_r == eetw_pkg::S_IDLE
      |=> tw_r == 3'h0 && rl_r == 3'h0 &&
      reg_rdata_r[15:13] == $past(rl_r) &&
      reg_rdata_r[10:8] == $past(tw_r))
      else $error("status read did not clear");
   chk_rsvd_zero: assert property (reg_rdata_r[12:11] == 2'b00)
      else $error("reserved status bits set");
   chk_fail_code: assert property (
      op_done && is_stop && fail_r && !job_rl_r && !rb_r &&
      state_nxt == eetw_pkg::S_IDLE |=> tw_r == 3'h5)
      else $error("refused access not reported failed");
   chk_rb_done: assert property (
      op_done && is_stop && rb_r && !job_rl_r |=> tw_r == 3'h1)
      else $error("read-back did not report done");
   chk_rl_busy: assert property (rl_busy |-> rl_r == 3'h2)
      else $error("reload status not busy");
   chk_rl_ignore: assert property (
      reg_wr && reg_addr == 5'h12 && reg_wdata[11] && rl_busy && !op_done
      |=> rl_r == 3'h2 && job_rl_r)
      else $error("second reload not ignored");
   chk_sda_stable: assert property (
      !is_start && !is_stop && state_r != eetw_pkg::S_IDLE &&
      !scl_oe_r && !$past(scl_oe_r) |-> $stable(sda_oe_r))
      else $error("data moved while clock high");

   cov_byte_read: cover property (job_rd_r && !job_rl_r && op_done &&
      is_rd ##[1:100] tw_r == 3'h1);
   cov_readback: cover property (rb_r && op_done && is_rd);
   cov_reload: cover property (rl_busy ##[1:1000] rl_r == 3'h1);
endmodule // eetw_two_wire_master

// ==== tb/eetw_eeprom_model.sv ====
// Behavioural two-wire configuration EEPROM, 256 bytes.
// Assumes open-drain wires with pull-ups built by the bench.
module eetw_eeprom_model #(
   parameter logic [6:0] DEV_ADDR = 7'h50
) (
   input wire logic scl,
   input wire logic sda,
   input wire logic nack_all,
   output logic sda_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [256];
   logic [7:0] sh;
   logic [7:0] ptr;
   int bitn;
   int st;
   initial begin
      sda_oe = 1'b0;
      st = 0;
      bitn = 0;
      ptr = 8'h00;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
   end
   // ****************************************************************
   // Framing, seen only with the clock line high
   // ****************************************************************
   always @(negedge sda) if (scl === 1'b1) begin
      st = 1;
      bitn = 0;
      sda_oe = 1'b0;
   end
   always @(posedge sda) if (scl === 1'b1) begin
      st = 0;
      sda_oe = 1'b0;
   end
   // ****************************************************************
   // Bits, MSB first, ninth bit acknowledge
   // ****************************************************************
   always @(posedge scl) if (st != 0) begin
      if (bitn < 8) begin
         if (st != 4) sh = {sh[6:0], sda};
         bitn++;
      end else if (bitn == 8) begin
         bitn = 9;
         if (st == 4 && sda) st = 0; // Master NACK ends read
      end
   end
   // Data changes only while the clock is low, then released at once
   always @(negedge scl) if (st != 0) begin
      if (bitn == 8) begin
         if (st == 4) sda_oe = 1'b0;
         else if (nack_all || (st == 1 && sh[7:1] != DEV_ADDR)) st = 0;
         else begin
            sda_oe = 1'b1;
            if (st == 1) st = sh[0] ? 4 : 2;
            else if (st == 2) begin
               ptr = sh;
               st = 3;
            end else begin
               mem[ptr] = sh;
               ptr++;
            end
         end
      end else if (bitn == 9) begin
         bitn = 0;
         sda_oe = 1'b0;
         if (st == 4) begin
            sh = mem[ptr];
            ptr++;
            sda_oe = ~sh[7];
         end
      end else if (st == 4) sda_oe = ~sh[7 - bitn];
   end
endmodule // eetw_eeprom_model

// ==== tb/eetw_two_wire_master_tb_top.sv ====
// Self-checking bench for the two-wire EEPROM master.
// Assumes the EEPROM model and the package are compiled first.
module eetw_two_wire_master_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic [7:0] ram_addr = 8'h00;
   logic nack_all = 1'b0;
   logic [15:0] reg_rdata_r;
   logic [15:0] s;
   logic [7:0] ram_data_r;
   logic scl_oe_r, sda_oe_r, phy_reinit_r, ee_oe;
   logic scl_out_r, sda_out_r;
   wire scl_w = ~scl_oe_r;
   wire sda_w = ~(sda_oe_r | ee_oe);
   int bad_count = 0;
   int num_checks = 0;
   int reinit_cnt = 0;
   always #50 clock = ~clock;
   always @(posedge clock) if (phy_reinit_r === 1'b1) reinit_cnt++;
   eetw_two_wire_master #(.WR_UNIT_CYC(4)) eetw_two_wire_master_i (
      .clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata_r(reg_rdata_r), .scl_in(scl_w), .scl_out_r(scl_out_r),
      .scl_oe_r(scl_oe_r), .sda_in(sda_w), .sda_out_r(sda_out_r),
      .sda_oe_r(sda_oe_r), .ram_addr(ram_addr), .ram_data_r(ram_data_r),
      .phy_reinit_r(phy_reinit_r));
   eetw_eeprom_model eetw_eeprom_model_i (
      .scl(scl_w), .sda(sda_w), .nack_all(nack_all), .sda_oe(ee_oe));
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wreg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rreg(input logic [4:0] a, output logic [15:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      d = reg_rdata_r;
   endtask
   // Polls status; reads taken while busy do not clear the busy code
   task automatic poll(input bit rl, output logic [15:0] d);
      for (int i = 0; i < 12000; i++) begin
         rreg(eetw_pkg::ADDR_STAT, d);
         if ((rl ? d[15:13] : d[10:8]) !== eetw_pkg::ST_BUSY) break;
      end
   endtask
   task automatic wait_idle;
      int q;
      q = 0;
      for (int i = 0; i < 2000 && q < 40; i++) begin
         @(posedge clock);
         q = (scl_oe_r === 1'b0 && sda_oe_r === 1'b0) ? q + 1 : 0;
      end
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset;
      rreg(eetw_pkg::ADDR_STAT, s);
      chk("stat", s, eetw_pkg::RST_STAT);
      rreg(eetw_pkg::ADDR_CMD, s);
      chk("cmd", s, eetw_pkg::RST_CMD);
      rreg(eetw_pkg::ADDR_CTRL, s);
      chk("ctrl", s, eetw_pkg::RST_CTRL);
      rreg(5'h05, s);
      chk("unmapped", s, 16'h0000);
      chk("pin lvl", {14'h0000, scl_out_r, sda_out_r}, 16'h0000);
   endtask
   task automatic t_write;
      wreg(eetw_pkg::ADDR_CTRL, 16'h003C);
      wreg(eetw_pkg::ADDR_CMD, 16'hA012);
      rreg(eetw_pkg::ADDR_STAT, s);
      chk("wr busy", s & 16'h0700, 16'h0200);
      poll(0, s);
      chk("wr done", s & 16'hFF00, 16'h0100);
      rreg(eetw_pkg::ADDR_STAT, s);
      chk("wr clear", s, 16'h0000);
      chk("wr mem", {8'h00, eetw_eeprom_model_i.mem[8'h12]}, 16'h003C);
   endtask
   task automatic t_read;
      wreg(eetw_pkg::ADDR_CMD, 16'hA112);
      poll(0, s);
      chk("rd data", s, 16'h013C);
   endtask
   task automatic t_busy;
      wreg(eetw_pkg::ADDR_CMD, 16'hA120);
      wreg(eetw_pkg::ADDR_CMD, 16'hA121);
      wreg(eetw_pkg::ADDR_CTRL, 16'h0800);
      rreg(eetw_pkg::ADDR_STAT, s);
      chk("rl ignored", s & 16'hFF00, 16'hE200);
      poll(0, s);
      chk("ignored", s, 16'h0185);
      rreg(eetw_pkg::ADDR_CTRL, s);
      chk("ctrl rl clr", s, 16'h0000);
   endtask
   // First a refused transfer, then an unread failure overwritten
   task automatic t_fail;
      nack_all = 1'b1;
      wreg(eetw_pkg::ADDR_CMD, 16'hA112);
      poll(0, s);
      chk("nack", s & 16'hFF00, 16'h0500);
      wreg(eetw_pkg::ADDR_CMD, 16'hA112);
      wait_idle();
      nack_all = 1'b0;
      wreg(eetw_pkg::ADDR_CMD, 16'hA120);
      poll(0, s);
      chk("overwrite", s, 16'h0185);
   endtask
   task automatic t_readback;
      wreg(eetw_pkg::ADDR_CTRL, 16'h0277);
      wreg(eetw_pkg::ADDR_CMD, 16'hA030);
      poll(0, s);
      chk("readback", s, 16'h0177);
   endtask
   // Refused reload in RAM-only mode: first block fails, no re-init
   task automatic t_rl_fail;
      nack_all = 1'b1;
      wreg(eetw_pkg::ADDR_CTRL, 16'h0800);
      poll(1, s);
      chk("rl fail", s & 16'hFF00, 16'hA000);
      nack_all = 1'b0;
      rreg(eetw_pkg::ADDR_CTRL, s);
      chk("rl self clr", s, 16'h0000);
      chk("no reinit", 16'(reinit_cnt), 16'h0000);
   endtask
   // Reload with re-init; a byte command and a reload arrive meanwhile
   task automatic t_reload;
      wreg(eetw_pkg::ADDR_CTRL, 16'h0C00);
      wreg(eetw_pkg::ADDR_CMD, 16'hA120);
      wreg(eetw_pkg::ADDR_CTRL, 16'h0800);
      rreg(eetw_pkg::ADDR_STAT, s);
      chk("rl busy", s & 16'hFF00, 16'h4700);
      poll(1, s);
      chk("rl done", s & 16'hFF00, 16'h2000);
      rreg(eetw_pkg::ADDR_STAT, s);
      // Reload bytes go to RAM; the read-back byte stays in the field
      chk("rl clear", s, 16'h0077);
      ram_addr <= 8'h80;
      @(posedge clock);
      @(posedge clock);
      @(negedge clock);
      chk("ram 80", {8'h00, ram_data_r}, 16'h0025);
      chk("reinit", 16'(reinit_cnt), 16'h0001);
   endtask
   task automatic test_done;
      if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_write();
      t_read();
      t_busy();
      t_fail();
      t_readback();
      t_rl_fail();
      t_reload();
      test_done();
   end
   // Reload alone needs about 24000 cycles
   initial begin
      repeat (90000) @(posedge clock);
      bad_count++;
      test_done();
   end
endmodule // eetw_two_wire_master_tb_top
